// File: design/tick_down_timer.sv
// Tick timer: 24-bit reloading down counter with memory-mapped registers
`timescale 1ns/10ps
module tick_down_timer
  import tick_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [23:0] calib_config_count,
  input wire logic calib_config_inexact,
  input wire logic calib_config_no_ref,
  output logic tick_irq
);
  logic enable;
  logic tick_irq_enable;
  logic clock_select;
  logic zero_reached_flag;
  logic [23:0] restart_value;
  logic [23:0] count;
  logic [23:0] calib_interval_count;
  logic calib_inexact_flag;
  logic ref_clock_absent;
  logic tick;
  logic reached_zero;
  logic wr_status;
  logic wr_restart;
  logic wr_count;
  logic rd_status;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
    hit = (addr == target);
  endfunction

  assign wr_status = reg_write && hit(reg_addr, ADDR_CONTROL_STATUS);
  assign wr_restart = reg_write && hit(reg_addr, ADDR_RESTART_VALUE);
  assign wr_count = reg_write && hit(reg_addr, ADDR_COUNT_NOW);
  assign rd_status = reg_read && hit(reg_addr, ADDR_CONTROL_STATUS);

  // ----------------------------------------------------------------
  // Tick enable
  // ----------------------------------------------------------------
  // Clock source bit is tied to zero (system rate) and ignores writes; reserved in the register view
  assign clock_select = 1'b0;

  tick_rate_divider u_divider (
    .clock(clock),
    .nrst(nrst),
    .run(enable),
    .use_half_rate(clock_select),
    .tick(tick)
  );

  assign reached_zero = tick && (count == RESET_COUNT);

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // control cleared at reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      enable <= 1'b0;
      tick_irq_enable <= 1'b0;
    end else if (wr_status) begin
      enable <= reg_wdata[BIT_ENABLE];
      tick_irq_enable <= reg_wdata[BIT_IRQ_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Restart value
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      restart_value <= RESET_RESTART;
    end else if (wr_restart) begin
      restart_value <= reg_wdata[COUNT_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= RESET_COUNT;
    end else if (wr_count) begin
      count <= RESET_COUNT;
    end else if (reached_zero) begin
      count <= restart_value;
    end else if (tick) begin
      count <= count - 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Zero-reached flag
  // ----------------------------------------------------------------
  // Set beats a clearing read so a zero crossing is never lost.
  // Count write clears only, since it also forces the count itself to zero.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      zero_reached_flag <= 1'b0;
    end else if (wr_count) begin
      zero_reached_flag <= 1'b0;
    end else if (reached_zero) begin
      zero_reached_flag <= 1'b1;
    end else if (rd_status) begin
      zero_reached_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // One-cycle pulse per zero crossing; the core latches it as an exception
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tick_irq <= 1'b0;
    end else begin
      tick_irq <= reached_zero && tick_irq_enable && !wr_count;
    end
  end

  // ----------------------------------------------------------------
  // Calibration mirror
  // ----------------------------------------------------------------
  // Configuration source is a same-domain register, so no synchroniser
  always_ff @(posedge clock) begin
    if (!nrst) begin
      calib_interval_count <= RESET_CALIB_COUNT;
      calib_inexact_flag <= RESET_CALIB_INEXACT;
      ref_clock_absent <= RESET_REF_ABSENT;
    end else begin
      calib_interval_count <= calib_config_count;
      calib_inexact_flag <= calib_config_inexact;
      ref_clock_absent <= calib_config_no_ref;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      reg_rdata <= 32'h00000000;
      if (hit(reg_addr, ADDR_CONTROL_STATUS)) begin
        reg_rdata[BIT_ENABLE] <= enable;
        reg_rdata[BIT_IRQ_ENABLE] <= tick_irq_enable;
        reg_rdata[BIT_CLOCK_SELECT] <= 1'b0;
        reg_rdata[BIT_ZERO_FLAG] <= zero_reached_flag;
      end else if (hit(reg_addr, ADDR_RESTART_VALUE)) begin
        reg_rdata[COUNT_WIDTH-1:0] <= restart_value;
      end else if (hit(reg_addr, ADDR_COUNT_NOW)) begin
        reg_rdata[COUNT_WIDTH-1:0] <= count;
      end else if (hit(reg_addr, ADDR_CALIBRATION)) begin
        reg_rdata[COUNT_WIDTH-1:0] <= calib_interval_count;
        reg_rdata[BIT_CALIB_INEXACT] <= calib_inexact_flag;
        reg_rdata[BIT_REF_ABSENT] <= ref_clock_absent;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_zero_tick;
    tick && count == 24'h000000 && !wr_count;
  endsequence

  a_hold_disabled: assert property (@(posedge clock) disable iff (!nrst)
    !enable && !wr_count |=> $stable(count))
    else $error("count moved while disabled");

  a_irq_on_zero: assert property (@(posedge clock) disable iff (!nrst)
    s_zero_tick and tick_irq_enable |=> tick_irq)
    else $error("missing tick interrupt");

  a_no_irq_masked: assert property (@(posedge clock) disable iff (!nrst)
    tick_irq |-> $past(tick_irq_enable))
    else $error("interrupt while masked");

  a_step_down: assert property (@(posedge clock) disable iff (!nrst)
    tick && count != 24'h000000 && !wr_count |=> count == $past(count) - 24'h000001)
    else $error("count did not step down");

  a_flag_set: assert property (@(posedge clock) disable iff (!nrst)
    s_zero_tick |=> zero_reached_flag)
    else $error("zero flag not set");

  a_reload_zero: assert property (@(posedge clock) disable iff (!nrst)
    s_zero_tick |=> count == $past(restart_value))
    else $error("no reload at zero");

  a_count_clear: assert property (@(posedge clock) disable iff (!nrst)
    wr_count |=> count == 24'h000000 && !zero_reached_flag)
    else $error("count write did not clear");

  a_read_count: assert property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr == ADDR_COUNT_NOW |=> reg_rdata == {8'h00, $past(count)})
    else $error("count read wrong");

  a_status_bit2: assert property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr == ADDR_CONTROL_STATUS |=> !reg_rdata[BIT_CLOCK_SELECT])
    else $error("reserved bit read one");

  a_reset_zero: assert property (@(posedge clock)
    !nrst |=> !enable && !tick_irq_enable && !zero_reached_flag && count == 24'h000000)
    else $error("state not zero after reset");

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  // Counting ticks keeps the period check free of long repetitions
  logic [23:0] period_ticks;
  logic period_valid;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      period_ticks <= 24'h000000;
    end else if (reached_zero || wr_count) begin
      period_ticks <= 24'h000000;
    end else if (tick) begin
      period_ticks <= period_ticks + 24'h000001;
    end
  end

  // a whole period follows a reload
  always_ff @(posedge clock) begin
    if (!nrst) begin
      period_valid <= 1'b0;
    end else if (wr_count || wr_restart) begin
      period_valid <= 1'b0;
    end else if (reached_zero) begin
      period_valid <= 1'b1;
    end
  end

  sequence s_status_read;
    reg_read && reg_addr == ADDR_CONTROL_STATUS;
  endsequence

  sequence s_flag_quiet;
    !reached_zero && !wr_count;
  endsequence

  a_flag_read_clear: assert property (@(posedge clock) disable iff (!nrst)
    s_status_read ##0 s_flag_quiet |=> !zero_reached_flag)
    else $error("zero flag not cleared by read");

  a_flag_sticky: assert property (@(posedge clock) disable iff (!nrst)
    zero_reached_flag && !rd_status && !wr_count |=> zero_reached_flag)
    else $error("zero flag dropped");

  a_flag_read_value: assert property (@(posedge clock) disable iff (!nrst)
    s_status_read |=> reg_rdata[BIT_ZERO_FLAG] == $past(zero_reached_flag))
    else $error("status read lost zero flag");

  a_no_irq_stopped: assert property (@(posedge clock) disable iff (!nrst)
    !enable |=> !tick_irq)
    else $error("interrupt while stopped");

  a_restart_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_restart |=> restart_value == $past(reg_wdata[COUNT_WIDTH-1:0]))
    else $error("restart value not stored");

  a_calib_read: assert property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr == ADDR_CALIBRATION |=> reg_rdata == {$past(ref_clock_absent),
    $past(calib_inexact_flag), 6'h00, $past(calib_interval_count)})
    else $error("calibration read wrong");

  a_reload_period: assert property (@(posedge clock) disable iff (!nrst)
    reached_zero && period_valid && !wr_count |-> period_ticks == restart_value)
    else $error("reload period wrong");

  a_irq_source: assert property (@(posedge clock) disable iff (!nrst)
    tick_irq |-> $past(reached_zero))
    else $error("interrupt without zero");
endmodule

// File: design/tick_pkg.sv
// Package: register map, field positions, reset values and timing for the tick timer
package tick_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CONTROL_STATUS = 32'hE000E010;
  localparam logic [31:0] ADDR_RESTART_VALUE = 32'hE000E014;
  localparam logic [31:0] ADDR_COUNT_NOW = 32'hE000E018;
  localparam logic [31:0] ADDR_CALIBRATION = 32'hE000E01C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 0;
  localparam int BIT_IRQ_ENABLE = 1;
  localparam int BIT_CLOCK_SELECT = 2;
  localparam int BIT_ZERO_FLAG = 16;
  localparam int BIT_CALIB_INEXACT = 30;
  localparam int BIT_REF_ABSENT = 31;
  localparam int COUNT_WIDTH = 24;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RESET_COUNT = 24'h000000;
  localparam logic [23:0] RESET_RESTART = 24'h000000;
  localparam logic [23:0] RESET_CALIB_COUNT = 24'h00001F;
  localparam logic RESET_CALIB_INEXACT = 1'b0;
  localparam logic RESET_REF_ABSENT = 1'b0;
  // ----------------------------------------------------------------
  // Timing: reference tick is system clock divided by two
  // ----------------------------------------------------------------
  localparam int REF_DIVIDE = 2;
endpackage

// File: design/tick_rate_divider.sv
// Tick enable generator: system rate or half system rate
`timescale 1ns/10ps
module tick_rate_divider
  import tick_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  input wire logic use_half_rate,
  output logic tick
);
  logic phase;
  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Phase only advances while running, so a stopped counter wakes cleanly
  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= 1'b0;
    end else if (run) begin
      phase <= ~phase;
    end else begin
      phase <= 1'b0;
    end
  end
  assign tick = run && (!use_half_rate || phase);
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the tick timer: registers, counting, flag and interrupt
`timescale 1ns/10ps
module tb_top;
  import tick_pkg::*;
  logic clock, nrst, reg_write, reg_read, calib_config_inexact, calib_config_no_ref, tick_irq;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, v, w;
  logic [23:0] calib_config_count;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  // ----------------------------------------------------------------
  // Clock, stimulus defaults and device
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 32'h00000000;
    reg_wdata = 32'h00000000;
    calib_config_count = 24'h00001F;
    calib_config_inexact = 1'b0;
    calib_config_no_ref = 1'b0;
  end
  tick_down_timer tick_down_timer_i (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .calib_config_count(calib_config_count),
    .calib_config_inexact(calib_config_inexact), .calib_config_no_ref(calib_config_no_ref), .tick_irq(tick_irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes rise and fall at falling edges, so each spans exactly one rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
  task automatic wait_irq(output int cyc);
    cyc = 0;
    do begin
      @(negedge clock);
      cyc++;
      if (cyc > 200) begin
        check("irq wait", 32'h00000000, 32'h00000001);
        test_done();
      end
    end while (tick_irq !== 1'b1);
  endtask
  task automatic no_irq(input int cyc);
    repeat (cyc) begin
      @(negedge clock);
      check("tick_irq", {31'h0, tick_irq}, 32'h00000000);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_and_map();
    rd(ADDR_CONTROL_STATUS, v); check("status rst", v, 32'h00000000);
    rd(ADDR_RESTART_VALUE, v); check("restart rst", v, 32'h00000000);
    rd(ADDR_COUNT_NOW, v); check("count rst", v, 32'h00000000);
    rd(ADDR_CALIBRATION, v); check("calib rst", v, 32'h0000001F);
    calib_config_count = 24'h123456;
    calib_config_inexact = 1'b1;
    calib_config_no_ref = 1'b1;
    wr(ADDR_CALIBRATION, 32'h00000000);
    rd(ADDR_CALIBRATION, v); check("calib mirror", v, 32'hC0123456);
    rd(32'hE000E020, v); check("unmapped", v, 32'h00000000);
    wr(ADDR_RESTART_VALUE, 32'hFFFFFFFF);
    rd(ADDR_RESTART_VALUE, v); check("restart field", v, 32'h00FFFFFF);
  endtask
  // Restart 3, started with 0x7 as software would, bit 2 written as one
  task automatic periodic_run();
    wr(ADDR_RESTART_VALUE, 32'h00000004 - 32'h00000001);
    wr(ADDR_COUNT_NOW, 32'h00000000);
    wr(ADDR_CONTROL_STATUS, 32'h00000007);
    wait_irq(n);
    wait_irq(n); check("period", n, 32'h00000004);
    wait_irq(n); check("period again", n, 32'h00000004);
    // Reload to 3 at the interrupt edge, then one tick passes before the read edge
    rd(ADDR_COUNT_NOW, v); check("count after zero", v, 32'h00000002);
    rd(ADDR_CONTROL_STATUS, v); check("status flag", v, 32'h00010003);
  endtask
  task automatic quiet_count();
    wr(ADDR_CONTROL_STATUS, 32'h00000001);
    no_irq(12);
    wr(ADDR_CONTROL_STATUS, 32'h00000002);
    rd(ADDR_CONTROL_STATUS, v); check("flag without irq", v, 32'h00010002);
    rd(ADDR_CONTROL_STATUS, v); check("flag cleared", v, 32'h00000002);
    rd(ADDR_COUNT_NOW, v);
    no_irq(10);
    rd(ADDR_COUNT_NOW, w); check("count holds", w, v);
    check("count in range", {31'h0, v <= 32'h00000003}, 32'h00000001);
  endtask
  task automatic count_write_clear();
    wr(ADDR_CONTROL_STATUS, 32'h00000001);
    repeat (9) @(negedge clock);
    wr(ADDR_CONTROL_STATUS, 32'h00000000);
    wr(ADDR_COUNT_NOW, 32'h00ABCDEF);
    rd(ADDR_COUNT_NOW, v); check("count cleared", v, 32'h00000000);
    rd(ADDR_CONTROL_STATUS, v); check("flag by write", v, 32'h00000000);
  endtask
  // Reload copied from the calibration interval, valid only at its intended clock
  task automatic calib_reload();
    calib_config_count = 24'h000005;
    rd(ADDR_CALIBRATION, v); check("calib live", v, 32'hC0000005);
    wr(ADDR_RESTART_VALUE, {8'h00, v[23:0]});
    wr(ADDR_COUNT_NOW, 32'h00000000);
    wr(ADDR_CONTROL_STATUS, 32'h00000007);
    wait_irq(n);
    wait_irq(n); check("calib period", n, 32'h00000006);
    rd(ADDR_CONTROL_STATUS, v); check("status running", v, 32'h00010003);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    reset_and_map();
    periodic_run();
    quiet_count();
    count_write_clear();
    calib_reload();
    test_done();
  end
endmodule
